// ---- hw/flag_ops.sv ----
/*
  flag_ops: single-cycle status flag set/clear and idle instructions,
  with the status flag register, program counter and an AXI4-Lite slave.
  assumes one clock, synchronous active-low reset, one write and one
  read outstanding at most.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
// Function
// - clear-zero writes 0 to zero flag in one cycle.
// - enable-interrupts sets, disable-interrupts clears interrupt enable, one cycle each.
// - set-signed writes 1, clear-signed writes 0 to signed flag, one cycle.
// - set-overflow forces 1, clear-overflow forces 0 on overflow flag, one cycle.
// - set-transfer drives 1, clear-transfer drives 0 on transfer flag, one cycle.
// - set-half-carry sets, clear-half-carry clears half carry flag, one cycle.
// - idle op takes one cycle; only program counter and issue count advance.
`timescale 1ns/1ps
module flag_ops
  import flag_ops_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output      logic [7:0]  status_flag_register,
  output      logic [15:0] program_counter
);

  core_state_t core_q;
  core_state_t core_d;
  wr_state_t   wr_q;
  wr_state_t   wr_d;
  logic [3:0]  awaddr_q;
  logic [3:0]  awaddr_d;
  logic        aw_have_q;
  logic        aw_have_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  wstrb_q;
  logic [3:0]  wstrb_d;
  logic        w_have_q;
  logic        w_have_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [3:0]  last_op_q;
  logic [3:0]  last_op_d;
  flag_op_t    op;
  logic        exec;
  logic        op_legal;
  logic [7:0]  flags_exec;

  assign s_axi_awready = (wr_q == wr_idle) && !aw_have_q;
  assign s_axi_wready  = (wr_q == wr_idle) && !w_have_q;
  assign s_axi_bvalid  = (wr_q == wr_resp);
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign status_flag_register = core_q.flags;
  assign program_counter      = core_q.pc;

  // instruction issue: a full write of the low byte to the instruction register
  assign op       = flag_op_t'(wdata_q[3:0]);
  assign op_legal = (wdata_q[3:0] <= 4'hb) && wstrb_q[0];
  assign exec     = (wr_q == wr_exec) && (awaddr_q == OFS_INSTR) && op_legal;

  // flag update; each set/clear op touches a single bit so all others hold
  always_comb
  begin
    flags_exec = core_q.flags;
    case (op)
      clear_zero_op:         flags_exec[FLAG_ZERO]     = 1'b0;
      enable_interrupts_op:  flags_exec[FLAG_INTEN]    = 1'b1;
      disable_interrupts_op: flags_exec[FLAG_INTEN]    = 1'b0;
      set_signed_op:         flags_exec[FLAG_SIGNED]   = 1'b1;
      clear_signed_op:       flags_exec[FLAG_SIGNED]   = 1'b0;
      set_overflow_op:       flags_exec[FLAG_OVERFLOW] = 1'b1;
      clear_overflow_op:     flags_exec[FLAG_OVERFLOW] = 1'b0;
      set_transfer_bit_op:   flags_exec[FLAG_TRANSFER] = 1'b1;
      clear_transfer_bit_op: flags_exec[FLAG_TRANSFER] = 1'b0;
      set_half_carry_op:     flags_exec[FLAG_HALF]     = 1'b1;
      clear_half_carry_op:   flags_exec[FLAG_HALF]     = 1'b0;
      idle_cycle_op:         flags_exec = core_q.flags;
      default:               flags_exec = core_q.flags;
    endcase
  end

  // write channel and execution
  always_comb
  begin
    wr_d      = wr_q;
    awaddr_d  = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    w_have_d  = w_have_q;
    bresp_d   = bresp_q;
    core_d    = core_q;
    count_d   = count_q;
    last_op_d = last_op_q;
    case (wr_q)
      wr_idle:
      begin
        // address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
          awaddr_d  = s_axi_awaddr;
          aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          wdata_d  = s_axi_wdata;
          wstrb_d  = s_axi_wstrb;
          w_have_d = 1'b1;
        end
        if (aw_have_q && w_have_q)
        begin
          wr_d = wr_exec;
        end
      end
      wr_exec:
      begin
        // the single execution cycle: an issued op updates flags and pc together
        bresp_d = RESP_OKAY;
        if (exec)
        begin
          core_d.flags = flags_exec;
          core_d.pc    = core_q.pc + 16'h0001;
          count_d      = count_q + 16'h0001;
          last_op_d    = wdata_q[3:0];
        end
        else if (awaddr_q == OFS_FLAGS)
        begin
          if (wstrb_q[0])
          begin
            core_d.flags = wdata_q[7:0];
          end
        end
        else if (awaddr_q == OFS_PC)
        begin
          if (wstrb_q[0])
          begin
            core_d.pc[7:0] = wdata_q[7:0];
          end
          if (wstrb_q[1])
          begin
            core_d.pc[15:8] = wdata_q[15:8];
          end
        end
        else
        begin
          // unknown op, unmapped or read-only offset
          bresp_d = RESP_SLVERR;
        end
        aw_have_d = 1'b0;
        w_have_d  = 1'b0;
        wr_d      = wr_resp;
      end
      wr_resp:
      begin
        if (s_axi_bready)
        begin
          wr_d = wr_idle;
        end
      end
      default:
      begin
        wr_d = wr_idle;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_q      <= wr_idle;
      awaddr_q  <= 4'h0;
      aw_have_q <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      w_have_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      core_q    <= '{flags: FLAGS_RESET, pc: PC_RESET};
      count_q   <= 16'h0000;
      last_op_q <= 4'h0;
    end
    else
    begin
      wr_q      <= wr_d;
      awaddr_q  <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      w_have_q  <= w_have_d;
      bresp_q   <= bresp_d;
      core_q    <= core_d;
      count_q   <= count_d;
      last_op_q <= last_op_d;
    end
  end

  // read channel; data registered one cycle after address
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_FLAGS: rdata_d = {24'h000000, core_q.flags};
        OFS_INSTR: rdata_d = {28'h0000000, last_op_q};
        OFS_PC:    rdata_d = {16'h0000, core_q.pc};
        OFS_COUNT: rdata_d = {16'h0000, count_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

endmodule

// ---- pkg/flag_ops_pkg.sv ----
/*
  flag_ops_pkg: shared constants and types for the status flag
  instruction unit: op codes, flag bit positions, register offsets.
  assumes a 32-bit AXI4-Lite register bus, byte addresses.
*/
package flag_ops_pkg;

  // op codes written to the instruction register (local encoding)
  typedef enum logic [3:0]
  {
    idle_cycle_op         = 4'h0,
    clear_zero_op         = 4'h1,
    enable_interrupts_op  = 4'h2,
    disable_interrupts_op = 4'h3,
    set_signed_op         = 4'h4,
    clear_signed_op       = 4'h5,
    set_overflow_op       = 4'h6,
    clear_overflow_op     = 4'h7,
    set_transfer_bit_op   = 4'h8,
    clear_transfer_bit_op = 4'h9,
    set_half_carry_op     = 4'ha,
    clear_half_carry_op   = 4'hb
  } flag_op_t;

  // flag positions in the status flag register
  localparam int unsigned FLAG_CARRY    = 0;
  localparam int unsigned FLAG_ZERO     = 1;
  localparam int unsigned FLAG_NEGATIVE = 2;
  localparam int unsigned FLAG_OVERFLOW = 3;
  localparam int unsigned FLAG_SIGNED   = 4;
  localparam int unsigned FLAG_HALF     = 5;
  localparam int unsigned FLAG_TRANSFER = 6;
  localparam int unsigned FLAG_INTEN    = 7;

  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [15:0] PC_RESET      = 16'h0000;

  // register byte offsets
  localparam logic [3:0] OFS_FLAGS  = 4'h0;
  localparam logic [3:0] OFS_INSTR  = 4'h4;
  localparam logic [3:0] OFS_PC     = 4'h8;
  localparam logic [3:0] OFS_COUNT  = 4'hc;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed
  {
    logic [7:0]  flags;
    logic [15:0] pc;
  } core_state_t;

  typedef enum logic [2:0]
  {
    wr_idle = 3'b001,
    wr_exec = 3'b010,
    wr_resp = 3'b100
  } wr_state_t;

endpackage

// ---- verification/flag_ops_props.sv ----
/* flag_ops_props: flag op checks on flag_ops ports.
   assumes bind to flag_ops, one write at a time. */
`timescale 1ns/1ps
module flag_ops_props
  import flag_ops_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  status_flag_register,
  input wire logic [15:0] program_counter
);
  logic [3:0] adr_q, adr_d, op_q, op_d;
  logic       bv_q, ex;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and op held until the next handshake
  always_comb
  begin
    adr_d = adr_q;
    op_d  = op_q;
    if (s_axi_awvalid && s_axi_awready) adr_d = s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) op_d = s_axi_wdata[3:0];
  end
  always_ff @(posedge aclk)
  begin
    adr_q <= adr_d;
    op_q  <= op_d;
    bv_q  <= s_axi_bvalid;
  end
  assign ex = s_axi_bvalid && !bv_q && s_axi_bresp == RESP_OKAY && adr_q == OFS_INSTR;
  a_clear_zero: assert property (ex && op_q == 4'h1 |-> !status_flag_register[FLAG_ZERO])
    else $error("zero flag not cleared");
  a_int_enable: assert property (ex && op_q[3:1] == 3'h1 |->
    status_flag_register[FLAG_INTEN] == !op_q[0]) else $error("interrupt enable wrong");
  a_signed_flag: assert property (ex && op_q[3:1] == 3'h2 |->
    status_flag_register[FLAG_SIGNED] == !op_q[0]) else $error("signed flag wrong");
  a_overflow_flag: assert property (ex && op_q[3:1] == 3'h3 |->
    status_flag_register[FLAG_OVERFLOW] == !op_q[0]) else $error("overflow flag wrong");
  a_transfer_bit: assert property (ex && op_q[3:1] == 3'h4 |->
    status_flag_register[FLAG_TRANSFER] == !op_q[0]) else $error("transfer flag wrong");
  a_half_carry: assert property (ex && op_q[3:1] == 3'h5 |->
    status_flag_register[FLAG_HALF] == !op_q[0]) else $error("half carry wrong");
  a_idle_cycle: assert property (ex && op_q == 4'h0 |-> $stable(status_flag_register)
    && program_counter == $past(program_counter) + 16'h1) else $error("idle op changed state");
  a_single_flag: assert property (ex |->
    $countones(status_flag_register ^ $past(status_flag_register)) <= 1)
    else $error("more than one flag changed");
  a_flags_at_done: assert property ($changed(status_flag_register) |-> $rose(s_axi_bvalid))
    else $error("flags changed outside a write");
  c_idle: cover property (ex && op_q == 4'h0);
  c_int: cover property (ex && op_q == 4'h2);
  c_err: cover property ($rose(s_axi_bvalid) && s_axi_bresp == RESP_SLVERR);
endmodule
bind flag_ops flag_ops_props flag_ops_props_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .status_flag_register, .program_counter);

// ---- verification/flag_ops_tb_top.sv ----
/* flag_ops_tb_top: seeded random flag ops over axi4-lite.
   assumes flag_ops_pkg and the props bind. */
`timescale 1ns/1ps
module flag_ops_tb_top
  import flag_ops_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  status_flag_register;
  logic [15:0] program_counter, pc_x, cnt_x;
  logic [3:0]  last_x;
  int          n_fail, n_checks, seed;
  flag_ops flag_ops_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .status_flag_register, .program_counter);
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    repeat (40)
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    n_fail++;
    finish_test();
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    repeat (40)
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        return;
      end
    end
    n_fail++;
    finish_test();
  endtask
  // expected flags; refused codes leave them alone
  function automatic logic [7:0] nf(input logic [7:0] f, input logic [3:0] op);
    int b;
    b = op < 2 ? FLAG_ZERO : op < 4 ? FLAG_INTEN : op < 6 ? FLAG_SIGNED :
        op < 8 ? FLAG_OVERFLOW : op < 10 ? FLAG_TRANSFER : FLAG_HALF;
    if (op != 4'h0 && op < 4'hc) f[b] = op != 4'h1 && !op[0];
    return f;
  endfunction
  task automatic op_run(input logic [3:0] op, input logic [7:0] f, input logic [3:0] s);
    logic [1:0]  r;
    logic [31:0] d;
    logic        ok;
    ok = op < 4'hc && s[0];
    wr(OFS_FLAGS, {24'h0, f}, 4'hf, r);
    wr(OFS_INSTR, {28'h0, op}, s, r);
    chk({32'h0, r}, {32'h0, ok ? RESP_OKAY : RESP_SLVERR});
    if (ok)
    begin
      pc_x   = pc_x + 16'h1;
      cnt_x  = cnt_x + 16'h1;
      last_x = op;
    end
    // a refused issue, bad code or missing low lane, leaves the flags alone
    rd(OFS_FLAGS, d, r);
    chk({d, r}, {24'h0, (ok ? nf(f, op) : f), RESP_OKAY});
    chk({18'h0, program_counter}, {18'h0, pc_x});
  endtask
  initial
  begin
    logic [31:0] x;
    logic [1:0]  r;
    int          i;
    {seed, n_fail, n_checks, pc_x, aresetn} = {32'h56fa2bf2, 64'h0, PC_RESET, 1'b0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {cnt_x, last_x} = 20'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_FLAGS, x, r);
    chk({x, r}, {24'h0, FLAGS_RESET, RESP_OKAY});
    // start near the top so the counter wraps
    wr(OFS_PC, 32'hfffe, 4'hf, r);
    pc_x = 16'hfffe;
    for (i = 0; i < 24; i++)
      op_run(i[4:1], {8{i[0]}}, 4'hf);
    op_run(4'h2, 8'h00, 4'he);
    for (i = 0; i < 60; i++)
    begin
      x = $random(seed);
      op_run(x[3:0], x[11:4], 4'hf);
    end
    wr(OFS_COUNT, 32'h0, 4'hf, r);
    chk({32'h0, r}, {32'h0, RESP_SLVERR});
    rd(4'h2, x, r);
    chk({x, r}, {32'h0, RESP_SLVERR});
    rd(OFS_COUNT, x, r);
    chk({x, r}, {16'h0, cnt_x, RESP_OKAY});
    rd(OFS_INSTR, x, r);
    chk({x, r}, {28'h0, last_x, RESP_OKAY});
    // upper pc lane only
    wr(OFS_PC, 32'h0000_a5c3, 4'h2, r);
    pc_x[15:8] = 8'ha5;
    chk({18'h0, program_counter}, {18'h0, pc_x});
    finish_test();
  end
endmodule
